// File: rtl/osp_addr_map.sv
module osp_addr_map (
	input  wire logic                      clock_i,    // core clock
	input  wire logic                      rst_n_i,    // sync reset, low
	input  wire logic [osp_pkg::ADDR_W-1:0] cpu_addr_i, // core bus address
	output logic                           ram_sel_o,  // on-chip ram hit
	output logic                           otp_sel_o   // on-chip otp hit
);
	import osp_pkg::*;

	logic ram_sel_d;
	logic otp_sel_d;

	always_comb begin
		ram_sel_d = osp_in_ram(cpu_addr_i); // [RULE_11]
		otp_sel_d = osp_in_otp(cpu_addr_i); // [RULE_11]
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			ram_sel_o <= 1'b0;
			otp_sel_o <= 1'b0;
		end else begin
			ram_sel_o <= ram_sel_d;
			otp_sel_o <= otp_sel_d;
		end
	end

	// ==========================================================
	// checks
	a_map_decode: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_11]
		##1 (ram_sel_o == osp_in_ram($past(cpu_addr_i)))
		&& (otp_sel_o == osp_in_otp($past(cpu_addr_i))))
		else $error("address map decode wrong");

endmodule

// File: rtl/osp_pkg.sv
package osp_pkg;

	// ==========================================================
	// timing base: one oscillator period is one clock cycle
	localparam int T_OSC_NS = 8;
	localparam int CLK_NS   = 8;

	function automatic int osp_cyc_min(input int tosc);
		int c;
		c = (tosc * T_OSC_NS + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int osp_cyc_max(input int tosc);
		int c;
		c = (tosc * T_OSC_NS) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int RESET_TO_STROBE_TOSC = 1100;
	localparam int RESET_TO_STROBE_CYC  = osp_cyc_min(RESET_TO_STROBE_TOSC);
	localparam int DUMP_VALID_TOSC      = 50;
	localparam int DUMP_VALID_CYC       = osp_cyc_max(DUMP_VALID_TOSC);
	localparam int VERIFY_VALID_TOSC    = 220;
	localparam int VERIFY_VALID_CYC     = osp_cyc_max(VERIFY_VALID_TOSC);
	localparam int VERIFY_HOLD_TOSC     = 50;
	localparam int VERIFY_HOLD_CYC      = osp_cyc_min(VERIFY_HOLD_TOSC);

	// ==========================================================
	// widths and reset values
	localparam int WORD_W    = 16;
	localparam int ADDR_W    = 16;
	localparam int MEM_AW    = 14;
	localparam int MEM_DEPTH = 16384;
	localparam int CNT_W     = 11;

	localparam logic [ADDR_W-1:0] ADDR_RST   = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_STEP  = 16'h0002;
	localparam logic [WORD_W-1:0] DATA_RST   = 16'h0000;
	localparam logic [CNT_W-1:0]  READY_CNT  = CNT_W'(RESET_TO_STROBE_CYC);
	localparam logic [CNT_W-1:0]  HOLD_CNT   = CNT_W'(VERIFY_HOLD_CYC);

	// ==========================================================
	// address map
	localparam logic [ADDR_W-1:0] RAM_LO = 16'h0200;
	localparam logic [ADDR_W-1:0] RAM_HI = 16'h03FF;
	localparam logic [ADDR_W-1:0] OTP_LO = 16'h6000;
	localparam logic [ADDR_W-1:0] OTP_HI = 16'h9FFF;

	function automatic logic osp_in_ram(input logic [ADDR_W-1:0] a);
		return (a >= RAM_LO) && (a <= RAM_HI);
	endfunction

	function automatic logic osp_in_otp(input logic [ADDR_W-1:0] a);
		return (a >= OTP_LO) && (a <= OTP_HI);
	endfunction

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_DUMP   = 2'b01,
		ST_PROGRAM_PULSE   = 2'b10,
		ST_VERIFY = 2'b11
	} osp_state_e;

endpackage

// File: rtl/osp_slave_port.sv
// Operation
// RULE_01 - The programmer waits at least 1100 periods after reset before its first address strobe.
// RULE_02 - In word dump the device presents read data within 50 periods of the program pulse falling.
// RULE_03 - The programmer waits 220 periods after the program pulse rises before the next strobe.
// RULE_04 - The programmer waits 220 periods after the strobe rises before lowering the program pulse.
// RULE_05 - The program line stays high at least 220 periods between program pulses.
// RULE_06 - The increment line may fall no earlier than the program pulse rising edge.
// RULE_07 - The verify output stays stable for at least 50 periods after the increment line falls.
// RULE_08 - The programmer waits 170 periods after the increment falls before the next program pulse.
// RULE_09 - The device drives a valid verify result within 220 periods after the program pulse rises.
// RULE_10 - The 50 period pulse width is for dump reads; real programming uses quick-pulse timing.
// RULE_11 - Addresses 0200H-03FFH map to on-chip ram and 6000H-9FFFH to on-chip otp memory.
// RULE_12 - Each completed increment pulse moves the programming address to the next word.
module osp_slave_port (
	input  wire logic                       clock_i,                    // core clock
	input  wire logic                       rst_n_i,                    // sync reset, low
	input  wire logic                       word_dump_i,                // 1 dump, 0 program
	input  wire logic                       program_pulse_addr_latch_strobe_n_i, // address strobe, low
	input  wire logic                       program_pulse_n_i,          // program pulse, low
	input  wire logic                       addr_increment_pulse_n_i,   // increment, low
	input  wire logic [osp_pkg::WORD_W-1:0] port_data_i,                // address / data in
	input  wire logic [osp_pkg::ADDR_W-1:0] cpu_addr_i,                 // core bus address
	output logic      [osp_pkg::WORD_W-1:0] port_data_o,                // dump data out
	output logic                            port_data_oe_o,             // dump data drive
	output logic                            verify_status_out_o,        // verify pass
	output logic      [osp_pkg::ADDR_W-1:0] program_pulse_addr_o,                // programming address
	output logic                            ram_sel_o,                  // on-chip ram hit
	output logic                            otp_sel_o                   // on-chip otp hit
);
	import osp_pkg::*;

	localparam int A_DUMP = DUMP_VALID_CYC;
	localparam int A_VER  = VERIFY_VALID_CYC;

	// ==========================================================
	// state
	osp_state_e        state_q, state_d;
	logic [CNT_W-1:0]  ready_cnt_q, ready_cnt_d;
	logic              ready_q, ready_d;
	logic [CNT_W-1:0]  hold_cnt_q, hold_cnt_d;
	logic              strobe_prev_q, pulse_prev_q, inc_prev_q;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [WORD_W-1:0] wdata_q, wdata_d;
	logic [WORD_W-1:0] dout_q, dout_d;
	logic              oe_q, oe_d;
	logic              ver_q, ver_d;
	logic              mem_we;
	logic [WORD_W-1:0] mem_wdata;
	logic [WORD_W-1:0] mem_rdata;
	logic              strobe_fall, pulse_fall, pulse_rise, inc_fall, inc_rise;
	logic              verify_done;

	// one-time cells only clear bits, so content is not reset
	logic [WORD_W-1:0] mem_q [MEM_DEPTH];

	assign mem_rdata   = mem_q[addr_q[MEM_AW:1]];
	assign strobe_fall = ready_q && strobe_prev_q && !program_pulse_addr_latch_strobe_n_i;
	assign pulse_fall  = ready_q && pulse_prev_q && !program_pulse_n_i;
	assign pulse_rise  = ready_q && !pulse_prev_q && program_pulse_n_i;
	assign inc_fall    = ready_q && inc_prev_q && !addr_increment_pulse_n_i;
	assign inc_rise    = ready_q && !inc_prev_q && addr_increment_pulse_n_i;
	// a fall seen in this very cycle already opens the hold window
	assign verify_done = (state_q == ST_VERIFY) && (hold_cnt_q == '0) && !inc_fall; // [RULE_07]

	// ==========================================================
	// next state
	always_comb begin
		state_d     = state_q;
		ready_cnt_d = ready_cnt_q;
		ready_d     = ready_q;
		hold_cnt_d  = hold_cnt_q;
		addr_d      = addr_q;
		wdata_d     = wdata_q;
		dout_d      = dout_q;
		oe_d        = oe_q;
		ver_d       = ver_q;
		mem_we      = 1'b0;
		mem_wdata   = mem_rdata & wdata_q;

		// strobes before the power-up window are ignored
		if (!ready_q) begin
			if (ready_cnt_q == READY_CNT - 1'b1) begin // [RULE_01]
				ready_d = 1'b1;
			end
			ready_cnt_d = ready_cnt_q + 1'b1;
		end

		if (inc_fall) begin
			hold_cnt_d = HOLD_CNT; // [RULE_07]
		end else if (hold_cnt_q != '0) begin
			hold_cnt_d = hold_cnt_q - 1'b1;
		end

		if (strobe_fall) begin
			addr_d = port_data_i;
		end else if (inc_rise) begin
			addr_d = addr_q + ADDR_STEP; // [RULE_12]
		end

		unique case (state_q)
			ST_IDLE: begin
				if (pulse_fall && word_dump_i) begin
					dout_d  = mem_rdata; // [RULE_02]
					oe_d    = 1'b1;
					state_d = ST_DUMP;
				end else if (pulse_fall) begin
					wdata_d = port_data_i;
					state_d = ST_PROGRAM_PULSE;
				end
			end
			ST_DUMP: begin
				if (pulse_rise) begin
					oe_d    = 1'b0;
					state_d = ST_IDLE;
				end
			end
			ST_PROGRAM_PULSE: begin
				// pulse length is the programmer's business, one write per pulse
				if (pulse_rise) begin // [RULE_10]
					mem_we  = 1'b1;
					state_d = ST_VERIFY;
				end
			end
			ST_VERIFY: begin
				// result waits out the hold window of a fresh increment
				if (verify_done) begin // [RULE_09] [RULE_07]
					ver_d   = (mem_rdata == wdata_q);
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_q       <= ST_IDLE;
			ready_cnt_q   <= '0;
			ready_q       <= 1'b0;
			hold_cnt_q    <= '0;
			strobe_prev_q <= 1'b1;
			pulse_prev_q  <= 1'b1;
			inc_prev_q    <= 1'b1;
			addr_q        <= ADDR_RST;
			wdata_q       <= DATA_RST;
			dout_q        <= DATA_RST;
			oe_q          <= 1'b0;
			ver_q         <= 1'b0;
		end else begin
			state_q       <= state_d;
			ready_cnt_q   <= ready_cnt_d;
			ready_q       <= ready_d;
			hold_cnt_q    <= hold_cnt_d;
			strobe_prev_q <= program_pulse_addr_latch_strobe_n_i;
			pulse_prev_q  <= program_pulse_n_i;
			inc_prev_q    <= addr_increment_pulse_n_i;
			addr_q        <= addr_d;
			wdata_q       <= wdata_d;
			dout_q        <= dout_d;
			oe_q          <= oe_d;
			ver_q         <= ver_d;
		end
	end

	always_ff @(posedge clock_i) begin
		if (mem_we) begin
			mem_q[addr_q[MEM_AW:1]] <= mem_wdata;
		end
	end

	assign port_data_o         = dout_q;
	assign port_data_oe_o      = oe_q;
	assign verify_status_out_o = ver_q;
	assign program_pulse_addr_o         = addr_q;

	osp_addr_map u_map (
		.clock_i    (clock_i),
		.rst_n_i    (rst_n_i),
		.cpu_addr_i (cpu_addr_i),
		.ram_sel_o  (ram_sel_o),
		.otp_sel_o  (otp_sel_o)
	);

	// ==========================================================
	// checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	a_dump_data_valid: assert property ( // [RULE_02]
		(pulse_fall && word_dump_i && state_q == ST_IDLE)
		|-> ##[1:A_DUMP] (port_data_oe_o && port_data_o == $past(mem_rdata)))
		else $error("dump data late or wrong");

	a_dump_release: assert property ( // [RULE_02]
		(pulse_rise && state_q == ST_DUMP) |=> !port_data_oe_o)
		else $error("dump drive not released");

	a_verify_hold: assert property ( // [RULE_07]
		(inc_fall || hold_cnt_q != '0) |=> $stable(verify_status_out_o))
		else $error("verify moved inside hold window");

	a_verify_valid: assert property ( // [RULE_09]
		(pulse_rise && state_q == ST_PROGRAM_PULSE) |-> ##[1:A_VER] verify_done)
		else $error("verify result late");

	a_verify_value: assert property ( // [RULE_09]
		verify_done |=> verify_status_out_o == ($past(mem_rdata) == wdata_q))
		else $error("verify result wrong");

	a_addr_step: assert property ( // [RULE_12]
		(inc_rise && !strobe_fall) |=> program_pulse_addr_o == $past(program_pulse_addr_o) + ADDR_STEP)
		else $error("address did not advance");

	a_no_early_strobe: assert property ( // [RULE_01]
		!ready_q |=> $stable(program_pulse_addr_o))
		else $error("strobe taken before ready");

	c_dump_read: cover property (pulse_fall && word_dump_i ##[1:A_DUMP] port_data_oe_o);
	c_program_pulse_verify: cover property (verify_done ##1 verify_status_out_o);
	c_verify_fail: cover property (verify_done ##1 !verify_status_out_o);
	c_addr_step: cover property (inc_rise);
	c_verify_held: cover property (pulse_rise && inc_fall && state_q == ST_PROGRAM_PULSE);

endmodule

// File: tb/osp_program_pulse_model.sv
module osp_program_pulse_model (
	input  wire logic                       clock_i,     // core clock
	input  wire logic [osp_pkg::WORD_W-1:0] dump_data_i, // device dump data
	input  wire logic                       dump_oe_i,   // device dump drive
	input  wire logic                       verify_i,    // device verify status
	output logic                            strobe_n_o,  // address strobe, low
	output logic                            pulse_n_o,   // program pulse, low
	output logic                            incr_n_o,    // increment, low
	output logic                            mode_o,      // 1 dump, 0 program
	output logic      [osp_pkg::WORD_W-1:0] data_o       // address / data
);
	timeunit 1ns;
	timeprecision 100ps;
	import osp_pkg::*;
	initial begin
		strobe_n_o = 1'b1;
		pulse_n_o = 1'b1;
		incr_n_o = 1'b1;
		mode_o = 1'b1;
		data_o = 16'h0000;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	// ==========================================================
	// released data shows the inverse, so a stale value never reads as held
	task automatic latch(input logic [WORD_W-1:0] a);
		data_o = a;
		strobe_n_o = 1'b0;
		tick(50);
		strobe_n_o = 1'b1;
		tick(50);
		data_o = ~a;
		tick(170);
	endtask
	task automatic pulse(input logic dump, input logic [WORD_W-1:0] d,
		output logic [WORD_W-1:0] got, output logic oe_in, output logic oe_out);
		mode_o = dump;
		data_o = d;
		pulse_n_o = 1'b0;
		tick(50);
		got = dump_data_i;
		oe_in = dump_oe_i;
		if (!dump) begin
			tick(350); // longer pulse keeps write data 400
		end
		pulse_n_o = 1'b1;
		tick(50);
		oe_out = dump_oe_i;
		data_o = ~d;
		tick(170);
	endtask
	// increment falls on the pulse rise, the tightest spacing allowed
	task automatic pulse_incr(input logic [WORD_W-1:0] d,
		output logic v_mid, output logic v_end);
		mode_o = 1'b0;
		data_o = d;
		pulse_n_o = 1'b0;
		tick(400);
		pulse_n_o = 1'b1;
		incr_n_o = 1'b0;
		tick(40);
		v_mid = verify_i;
		data_o = ~d;
		tick(200);
		v_end = verify_i;
		incr_n_o = 1'b1;
		tick(3);
	endtask
	task automatic incr(output logic v0, output logic v1);
		incr_n_o = 1'b0; // only ever after a pulse rise
		v0 = verify_i;
		tick(50);
		v1 = verify_i;
		tick(190);
		incr_n_o = 1'b1;
		tick(3);
	endtask
endmodule

// File: tb/otprom_slave_program_port_tb.sv
`define CHK(nm, exp, got) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("unexpected %s expected %h seen %h", nm, exp, got); \
	end \
end

module otprom_slave_program_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import osp_pkg::*;
	logic              clock_i, rst_n_i, strobe_n, pulse_n, incr_n, mode;
	logic              oe, verify, ram_sel, otp_sel;
	logic [WORD_W-1:0] data_in, data_out;
	logic [ADDR_W-1:0] cpu_addr, program_pulse_addr;
	int                fail_count = 0;
	int                comparisons = 0;
	int                cycles = 0;

	osp_slave_port dut_u (
		.clock_i                    (clock_i),
		.rst_n_i                    (rst_n_i),
		.word_dump_i                (mode),
		.program_pulse_addr_latch_strobe_n_i (strobe_n),
		.program_pulse_n_i          (pulse_n),
		.addr_increment_pulse_n_i   (incr_n),
		.port_data_i                (data_in),
		.cpu_addr_i                 (cpu_addr),
		.port_data_o                (data_out),
		.port_data_oe_o             (oe),
		.verify_status_out_o        (verify),
		.program_pulse_addr_o                (program_pulse_addr),
		.ram_sel_o                  (ram_sel),
		.otp_sel_o                  (otp_sel)
	);
	osp_program_pulse_model program_pulse_u (
		.clock_i     (clock_i),
		.dump_data_i (data_out),
		.dump_oe_i   (oe),
		.verify_i    (verify),
		.strobe_n_o  (strobe_n),
		.pulse_n_o   (pulse_n),
		.incr_n_o    (incr_n),
		.mode_o      (mode),
		.data_o      (data_in)
	);

	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	// ==========================================================
	// whole run needs about 4000 cycles
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ==========================================================
	task automatic t_early();
		program_pulse_u.tick(100);
		program_pulse_u.latch(16'h1234);
		`CHK("early program_pulse_addr", 16'h0000, program_pulse_addr)
		program_pulse_u.tick(800); // next strobe lands past 1100 cycles
	endtask
	// uninitialised cells: clearing to zero is the only known write
	task automatic t_program();
		logic [WORD_W-1:0] got;
		logic              oi, oo, vm, ve;
		program_pulse_u.latch(16'h6000);
		`CHK("latched program_pulse_addr", 16'h6000, program_pulse_addr)
		program_pulse_u.pulse(1'b0, 16'h0000, got, oi, oo);
		`CHK("verify clear word", 1'b1, verify)
		program_pulse_u.pulse(1'b1, 16'hFFFF, got, oi, oo);
		`CHK("dump data", 16'h0000, got)
		`CHK("dump drive", 1'b1, oi)
		`CHK("dump release", 1'b0, oo)
		// cleared word cannot take set bits, so the result turns to fail after the hold
		program_pulse_u.pulse_incr(16'h1234, vm, ve);
		`CHK("verify held after increment", 1'b1, vm)
		`CHK("verify set bits", 1'b0, ve)
		`CHK("pulse increment addr", 16'h6002, program_pulse_addr)
	endtask
	task automatic t_incr();
		logic [WORD_W-1:0] got;
		logic              oi, oo, v0, v1;
		program_pulse_u.incr(v0, v1);
		`CHK("verify hold fail", 1'b0, v1)
		`CHK("incremented addr", 16'h6004, program_pulse_addr)
		program_pulse_u.pulse(1'b0, 16'h0000, got, oi, oo);
		`CHK("verify next word", 1'b1, verify)
		program_pulse_u.incr(v0, v1);
		`CHK("verify hold start", 1'b1, v0)
		`CHK("verify hold pass", 1'b1, v1)
		`CHK("second increment", 16'h6006, program_pulse_addr)
	endtask
	task automatic t_map();
		logic [ADDR_W-1:0] tbl [8] = '{16'h01FF, 16'h0200, 16'h03FF, 16'h0400,
			16'h5FFF, 16'h6000, 16'h9FFF, 16'hA000};
		foreach (tbl[i]) begin
			cpu_addr = tbl[i];
			program_pulse_u.tick(2);
			`CHK("ram select", (tbl[i] >= 16'h0200 && tbl[i] <= 16'h03FF), ram_sel)
			`CHK("otp select", (tbl[i] >= 16'h6000 && tbl[i] <= 16'h9FFF), otp_sel)
		end
	endtask

	initial begin
		rst_n_i = 1'b0;
		cpu_addr = 16'h0000;
		repeat (12) @(posedge clock_i);
		#1;
		rst_n_i = 1'b1;
		t_early();
		t_program();
		t_incr();
		t_map();
		tally_and_finish();
	end
endmodule
